// ==== rtl/mxi_alu.sv ====
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "mxi_alu_map.svh"
module mxi_alu #(
  parameter int MULS_CYC = `MXI_MULS_CYC,
  parameter int TBL_CYC = `MXI_TBL_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic issue,
  input wire logic op_page2,
  input wire logic [7:0] op_code,
  input wire logic [7:0] op_post,
  input wire logic [7:0] mem_byte,
  input wire logic [15:0] eff_addr,
  input wire logic next_page2,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic tbl_rd,
  output logic [15:0] tbl_addr,
  input wire logic [15:0] tbl_rdata,
  output logic [7:0] acc_a,
  output logic [7:0] acc_b,
  output logic [15:0] idx_y,
  output logic [7:0] condition_flag_register
);
  // refuse counts the 4-bit counter cannot serve
  if (MULS_CYC < 2 || MULS_CYC > 14) begin
    $error("mxi_alu: MULS_CYC out of range");
  end
  if (TBL_CYC < 6 || TBL_CYC > 15) begin
    $error("mxi_alu: TBL_CYC out of range");
  end

  localparam logic [3:0] MULS_CNT = 4'(MULS_CYC - 1);
  localparam logic [3:0] MULS_CNT_X = 4'(MULS_CYC - 1 + `MXI_MULS_EXTRA);
  localparam logic [3:0] TBL_CNT = 4'(TBL_CYC - 1);

  // indexed forms usable by the interpolation
  function automatic logic post_ok(input logic [7:0] pb);
    logic is_acc;
    is_acc = pb[2] && (pb[1:0] != 2'b11);
    post_ok = (pb[7:5] != 3'b111) || is_acc;
  endfunction

  function automatic logic [7:0] flags8(input logic [7:0] cfr,
                                        input logic [7:0] r);
    logic [7:0] f;
    f = cfr;
    f[`MXI_CFR_N] = r[7];
    f[`MXI_CFR_Z] = (r == 8'h00);
    f[`MXI_CFR_V] = 1'b0;
    flags8 = f;
  endfunction

  mxi_alu_pkg::mxi_state_t state_q, state_d;
  logic [7:0] a_q, b_q, cfr_q;
  logic [15:0] y_q;
  logic [31:0] prod_q;
  logic [7:0] frac_q;
  logic [15:0] ea_q, y1_q, y2_q;
  logic [3:0] cnt_q;
  logic rd_q;
  logic [15:0] addr_q;
  logic done_q, ill_q, ill_seen_q;
  logic [15:0] rdata_q;

  mxi_interp_if ipf ();
  mxi_interp u_interp (
    .ifc(ipf.arith)
  );
  assign ipf.frac = frac_q;
  assign ipf.y1 = y1_q;
  assign ipf.y2 = y2_q;

  wire idle = (state_q == mxi_alu_pkg::ST_IDLE);
  wire take = issue && idle;
  wire [15:0] d_now = {a_q, b_q};

  // decode
  wire is_xa = !op_page2 && (op_code == `MXI_OP_XA_IMM ||
    op_code == `MXI_OP_XA_DIR || op_code == `MXI_OP_XA_EXT ||
    op_code == `MXI_OP_XA_IDX);
  wire is_xb = !op_page2 && (op_code == `MXI_OP_XB_IMM ||
    op_code == `MXI_OP_XB_DIR || op_code == `MXI_OP_XB_EXT ||
    op_code == `MXI_OP_XB_IDX);
  wire is_muls = op_page2 && (op_code == `MXI_OP_MULS);
  wire is_tbl = op_page2 && (op_code == `MXI_OP_TBL);
  wire tbl_bad = is_tbl && !post_ok(op_post);
  mxi_alu_pkg::mxi_op_t op_sel;
  assign op_sel = !take ? mxi_alu_pkg::OP_NONE :
                  is_muls ? mxi_alu_pkg::OP_MULS :
                  is_xa ? mxi_alu_pkg::OP_XOR_A :
                  is_xb ? mxi_alu_pkg::OP_XOR_B :
                  (is_tbl && !tbl_bad) ? mxi_alu_pkg::OP_TBL :
                  mxi_alu_pkg::OP_NONE;

  // signed multiply product
  wire signed [31:0] muls_full = $signed(d_now) * $signed(y_q);

  // exclusive-OR results
  wire [7:0] xa_res = a_q ^ mem_byte;
  wire [7:0] xb_res = b_q ^ mem_byte;

  // completion strobes
  wire cnt_last = (cnt_q == 4'h1);
  wire muls_commit = (state_q == mxi_alu_pkg::ST_MULS) && cnt_last;
  wire tbl_commit = (state_q == mxi_alu_pkg::ST_TBL_WAIT) && cnt_last;
  wire xa_commit = (op_sel == mxi_alu_pkg::OP_XOR_A);
  wire xb_commit = (op_sel == mxi_alu_pkg::OP_XOR_B);
  wire any_commit = muls_commit || tbl_commit || xa_commit || xb_commit;

  // multiply flags
  logic [7:0] cfr_muls;
  always_comb begin
    cfr_muls = cfr_q;
    cfr_muls[`MXI_CFR_N] = prod_q[31];
    cfr_muls[`MXI_CFR_Z] = (prod_q == 32'h00000000);
    cfr_muls[`MXI_CFR_C] = prod_q[15];
  end

  // interpolation flags
  logic [7:0] cfr_tbl;
  always_comb begin
    cfr_tbl = cfr_q;
    cfr_tbl[`MXI_CFR_N] = ipf.result[15];
    cfr_tbl[`MXI_CFR_Z] = (ipf.result == 16'h0000);
    cfr_tbl[`MXI_CFR_C] = ipf.round_up;
  end

  // register port decode
  wire wr_d = reg_wr && (reg_addr == `MXI_OFS_D);
  wire wr_y = reg_wr && (reg_addr == `MXI_OFS_Y);
  wire wr_cfr = reg_wr && (reg_addr == `MXI_OFS_CFR);
  wire wr_stat = reg_wr && (reg_addr == `MXI_OFS_STAT);
  wire ill_clr = wr_stat && reg_wdata[`MXI_STAT_ILL];
  wire [15:0] stat_word = {14'h0000, ill_seen_q, !idle};
  wire [15:0] rd_mux = (reg_addr == `MXI_OFS_D) ? d_now :
                       (reg_addr == `MXI_OFS_Y) ? y_q :
                       (reg_addr == `MXI_OFS_CFR) ? {8'h00, cfr_q} :
                       (reg_addr == `MXI_OFS_STAT) ? stat_word :
                       16'h0000;

  // next accumulator, index and flag values; writeback beats software
  logic [7:0] a_d, b_d, cfr_d;
  logic [15:0] y_d;
  always_comb begin
    a_d = a_q;
    b_d = b_q;
    y_d = y_q;
    cfr_d = cfr_q;
    if (wr_d) begin
      a_d = reg_wdata[15:8];
      b_d = reg_wdata[7:0];
    end
    if (wr_y) begin
      y_d = reg_wdata;
    end
    if (wr_cfr) begin
      cfr_d = reg_wdata[7:0];
    end
    if (muls_commit) begin
      y_d = prod_q[31:16];
      a_d = prod_q[15:8];
      b_d = prod_q[7:0];
      cfr_d = cfr_muls;
    end else if (tbl_commit) begin
      a_d = ipf.result[15:8];
      b_d = ipf.result[7:0];
      cfr_d = cfr_tbl;
    end else if (xa_commit) begin
      a_d = xa_res;
      cfr_d = flags8(cfr_q, xa_res);
    end else if (xb_commit) begin
      b_d = xb_res;
      cfr_d = flags8(cfr_q, xb_res);
    end
  end

  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      mxi_alu_pkg::ST_IDLE: begin
        if (op_sel == mxi_alu_pkg::OP_MULS) begin
          state_d = mxi_alu_pkg::ST_MULS;
        end else if (op_sel == mxi_alu_pkg::OP_TBL) begin
          state_d = mxi_alu_pkg::ST_TBL_A1;
        end
      end
      mxi_alu_pkg::ST_MULS: begin
        if (cnt_last) begin
          state_d = mxi_alu_pkg::ST_IDLE;
        end
      end
      mxi_alu_pkg::ST_TBL_A1: state_d = mxi_alu_pkg::ST_TBL_A2;
      mxi_alu_pkg::ST_TBL_A2: state_d = mxi_alu_pkg::ST_TBL_D1;
      mxi_alu_pkg::ST_TBL_D1: state_d = mxi_alu_pkg::ST_TBL_WAIT;
      mxi_alu_pkg::ST_TBL_WAIT: begin
        if (cnt_last) begin
          state_d = mxi_alu_pkg::ST_IDLE;
        end
      end
      default: state_d = mxi_alu_pkg::ST_IDLE;
    endcase
  end

  wire [3:0] cnt_start = (op_sel == mxi_alu_pkg::OP_TBL) ? TBL_CNT :
                         next_page2 ? MULS_CNT_X : MULS_CNT;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= mxi_alu_pkg::ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (take) begin
        cnt_q <= cnt_start;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      a_q <= `MXI_RST_A;
      b_q <= `MXI_RST_B;
      y_q <= `MXI_RST_Y;
      cfr_q <= `MXI_RST_CFR;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      y_q <= y_d;
      cfr_q <= cfr_d;
    end
  end

  // operand capture at issue
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prod_q <= 32'h00000000;
      frac_q <= 8'h00;
      ea_q <= 16'h0000;
    end else if (take) begin
      prod_q <= muls_full;
      frac_q <= b_q;
      ea_q <= eff_addr;
    end
  end

  // table reads: entry at ea, then at ea plus 2
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      addr_q <= 16'h0000;
      y1_q <= 16'h0000;
      y2_q <= 16'h0000;
    end else begin
      rd_q <= (op_sel == mxi_alu_pkg::OP_TBL) ||
              (state_q == mxi_alu_pkg::ST_TBL_A1);
      if (op_sel == mxi_alu_pkg::OP_TBL) begin
        addr_q <= eff_addr;
      end else if (state_q == mxi_alu_pkg::ST_TBL_A1) begin
        addr_q <= ea_q + `MXI_TBL_STEP;
      end
      if (state_q == mxi_alu_pkg::ST_TBL_A2) begin
        y1_q <= tbl_rdata;
      end
      if (state_q == mxi_alu_pkg::ST_TBL_D1) begin
        y2_q <= tbl_rdata;
      end
    end
  end

  // status, strobes and read data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
      ill_seen_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= any_commit;
      ill_q <= take && tbl_bad;
      if (take && tbl_bad) begin
        ill_seen_q <= 1'b1;
      end else if (ill_clr) begin
        ill_seen_q <= 1'b0;
      end
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign busy = !idle;
  assign done = done_q;
  assign illegal = ill_q;
  assign tbl_rd = rd_q;
  assign tbl_addr = addr_q;
  assign acc_a = a_q;
  assign acc_b = b_q;
  assign idx_y = y_q;
  assign condition_flag_register = cfr_q;
endmodule

// ==== common/mxi_alu_map.svh ====
// Overview of operation
// - the signed wide multiply takes the double accumulator and Y as signed 16-bit values and forms a full signed 32-bit product.
// - after the signed wide multiply, Y receives product bits 31:16 and the double accumulator receives bits 15:0.
// - the signed wide multiply sets N from product bit 31, Z only for a zero 32-bit product, and C from product bit 15.
// - the signed wide multiply decodes from prefix 18 then 13, lasts three cycles, and one more when a second-page opcode follows.
// - xor_first_accumulator replaces the first accumulator with its old value exclusive-ORed with the memory byte.
// - xor_second_accumulator writes the second accumulator exclusive-ORed with the memory byte back into the second accumulator.
// - both exclusive-OR forms set N from result bit 7, Z for a zero byte, clear V and keep C.
// - xor_first_accumulator decodes from 88 immediate, 98 direct, B8 extended and A8 with a postbyte for indexed.
// - xor_second_accumulator decodes from C8 immediate, D8 direct, F8 extended and E8 with a postbyte for indexed.
// - table_interpolate_wide puts Y1 plus fraction times (Y2 minus Y1) into the double accumulator, one of 256 points per segment.
// - interpolation reads the first entry at the effective address and the second at the effective address plus 2.
// - the fraction times the entry difference is a 24-bit value with its binary point between bits 7 and 8, and its top 16 bits add to Y1.
// - the interpolated result is not rounded, and C is set when the dropped fraction would round it up.
// - interpolation accepts only indexed forms that are neither indirect nor 9-bit or 16-bit constant offset.
// - interpolation sets N from result bit 15 and Z when the 16-bit result is zero.
`ifndef MXI_ALU_MAP_SVH
`define MXI_ALU_MAP_SVH
`define MXI_OFS_D 8'h00
`define MXI_OFS_Y 8'h01
`define MXI_OFS_CFR 8'h02
`define MXI_OFS_STAT 8'h03
`define MXI_STAT_BUSY 0
`define MXI_STAT_ILL 1
`define MXI_RST_A 8'h00
`define MXI_RST_B 8'h00
`define MXI_RST_Y 16'h0000
`define MXI_RST_CFR 8'hD0
`define MXI_CFR_N 3
`define MXI_CFR_Z 2
`define MXI_CFR_V 1
`define MXI_CFR_C 0
`define MXI_OP_PAGE2 8'h18
`define MXI_OP_MULS 8'h13
`define MXI_OP_TBL 8'h3F
`define MXI_OP_XA_IMM 8'h88
`define MXI_OP_XA_DIR 8'h98
`define MXI_OP_XA_EXT 8'hB8
`define MXI_OP_XA_IDX 8'hA8
`define MXI_OP_XB_IMM 8'hC8
`define MXI_OP_XB_DIR 8'hD8
`define MXI_OP_XB_EXT 8'hF8
`define MXI_OP_XB_IDX 8'hE8
`define MXI_MULS_CYC 3
`define MXI_MULS_EXTRA 1
`define MXI_TBL_CYC 9
`define MXI_TBL_STEP 16'h0002
`endif

// ==== common/mxi_alu_pkg.sv ====
package mxi_alu_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MULS,
    ST_TBL_A1,
    ST_TBL_A2,
    ST_TBL_D1,
    ST_TBL_WAIT
  } mxi_state_t;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_MULS,
    OP_XOR_A,
    OP_XOR_B,
    OP_TBL
  } mxi_op_t;
endpackage

// ==== common/mxi_interp_if.sv ====
`timescale 1ns/1ps
interface mxi_interp_if;
  logic [7:0] frac;
  logic [15:0] y1;
  logic [15:0] y2;
  logic [15:0] result;
  logic round_up;
  modport alu (output frac, output y1, output y2,
               input result, input round_up);
  modport arith (input frac, input y1, input y2,
                 output result, output round_up);
endinterface

// ==== rtl/mxi_interp.sv ====
`timescale 1ns/1ps
module mxi_interp (
  mxi_interp_if.arith ifc
);
  wire [15:0] diff;
  wire signed [24:0] prod;
  wire [15:0] step;
  assign diff = ifc.y2 - ifc.y1;
  // signed difference times unsigned fraction, point between bits 7 and 8
  assign prod = $signed(diff) * $signed({1'b0, ifc.frac});
  assign step = prod[23:8];
  assign ifc.result = ifc.y1 + step;
  // dropped half or more means rounding up is possible
  assign ifc.round_up = prod[7];
endmodule

// ==== bench/mxi_alu_asserts.sv ====
`timescale 1ns/1ps
module mxi_alu_asserts #(
  parameter int MULS_CYC = 3,
  parameter int TBL_CYC = 9
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic op_page2,
  input wire logic [7:0] op_code,
  input wire logic [7:0] op_post,
  input wire logic [7:0] mem_byte,
  input wire logic [15:0] eff_addr,
  input wire logic next_page2,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic tbl_rd,
  input wire logic [15:0] tbl_addr,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [15:0] idx_y,
  input wire logic [7:0] condition_flag_register
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic signed [31:0] prod;
  logic [7:0] cf;
  logic go, xa, xb, mul, tbl, ok;
  assign cf = condition_flag_register;
  assign prod = $signed({acc_a, acc_b}) * $signed(idx_y);
  assign go = issue && !busy && !op_page2;
  assign xa = go && op_code inside {8'h88, 8'h98, 8'hB8, 8'hA8};
  assign xb = go && op_code inside {8'hC8, 8'hD8, 8'hF8, 8'hE8};
  assign mul = issue && !busy && op_page2 && op_code == 8'h13;
  assign tbl = issue && !busy && op_page2 && op_code == 8'h3F;
  assign ok = (op_post[7:5] != 3'b111) ||
    (op_post[2] && op_post[1:0] != 2'b11);
  a_xor_first: assert property (xa |=> done &&
    acc_a == ($past(acc_a) ^ $past(mem_byte))) else $error("xor a wrong");
  a_xor_second: assert property (xb |=> done &&
    acc_b == ($past(acc_b) ^ $past(mem_byte))) else $error("xor b wrong");
  a_xor_flags: assert property (xa |=> cf ==
    {$past(cf[7:4]), acc_a[7], acc_a == 8'h00, 1'b0, $past(cf[0])})
    else $error("xor flags wrong");
  a_mul_result: assert property (mul && !next_page2 |->
    ##1 busy [*2] ##1 done && {idx_y, acc_a, acc_b} == $past(prod, 3))
    else $error("multiply result wrong");
  a_mul_flags: assert property (mul && !next_page2 |-> ##3
    cf[3] == $past(prod[31], 3) && cf[2] == ($past(prod, 3) == 0) &&
    cf[0] == $past(prod[15], 3) && cf[7:4] == $past(cf[7:4], 3))
    else $error("multiply flags wrong");
  a_mul_extra: assert property (mul && next_page2 |->
    ##3 !done ##1 done) else $error("multiply extra cycle wrong");
  a_tbl_reads: assert property (tbl && ok |=> tbl_rd &&
    tbl_addr == $past(eff_addr) ##1 tbl_rd &&
    tbl_addr == $past(eff_addr, 2) + 16'h0002) else $error("reads wrong");
  a_tbl_refused: assert property (tbl && !ok |=>
    illegal && !tbl_rd) else $error("bad postbyte accepted");
  a_tbl_flags: assert property (tbl && ok |-> ##9 done &&
    cf[3] == acc_a[7] && cf[2] == ({acc_a, acc_b} == 16'h0000) &&
    cf[1] == $past(cf[1], 9)) else $error("interpolate flags wrong");
endmodule
bind mxi_alu mxi_alu_asserts #(.MULS_CYC(MULS_CYC), .TBL_CYC(TBL_CYC))
  mxi_alu_asserts_inst (.core_clk, .rst_n, .issue, .op_page2, .op_code,
  .op_post, .mem_byte, .eff_addr, .next_page2, .busy, .done, .illegal,
  .tbl_rd, .tbl_addr, .acc_a, .acc_b, .idx_y, .condition_flag_register);

// ==== bench/mxi_tbl_mem.sv ====
`timescale 1ns/1ps
module mxi_tbl_mem (
  input wire logic core_clk,
  input wire logic tbl_rd,
  input wire logic [15:0] tbl_addr,
  output logic [15:0] tbl_rdata
);
  logic [15:0] mem [256];
  initial tbl_rdata = 16'h0000;
  // idle cycles toggle the data so stale values never look valid
  always @(posedge core_clk) begin
    if (tbl_rd) tbl_rdata <= mem[tbl_addr[8:1]];
    else tbl_rdata <= ~tbl_rdata;
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic core_clk, rst_n, reg_wr, reg_rd, issue, op_page2, next_page2;
  logic busy, done, illegal, tbl_rd;
  logic [7:0] reg_addr, op_code, op_post, mem_byte, acc_a, acc_b;
  logic [7:0] condition_flag_register, c, r8, ops [8], bad [5];
  logic [15:0] reg_wdata, reg_rdata, eff_addr, tbl_addr, tbl_rdata, idx_y;
  logic [15:0] d, y, e;
  logic [16:0] r;
  logic [31:0] p;
  int n_fail, n_checks, cyc, n;
  integer seed;
  mxi_alu mxi_alu_inst (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .issue, .op_page2, .op_code, .op_post, .mem_byte,
    .eff_addr, .next_page2, .busy, .done, .illegal, .tbl_rd, .tbl_addr,
    .tbl_rdata, .acc_a, .acc_b, .idx_y, .condition_flag_register);
  mxi_tbl_mem mxi_tbl_mem_inst (.core_clk, .tbl_rd, .tbl_addr, .tbl_rdata);
  function automatic logic [31:0] smul(input logic signed [15:0] a, b);
    return a * b;
  endfunction
  function automatic logic [16:0] interp(input logic [15:0] a, b,
                                         input logic [7:0] f);
    logic [23:0] q;
    q = $signed(b - a) * $signed({1'b0, f});
    return {q[7], a + q[23:8]};
  endfunction
  task automatic wrap_up;
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic run(input logic p2, input logic [7:0] op, pb, mb,
                     input logic [15:0] ea, input logic np);
    @(posedge core_clk);
    issue <= 1'b1;
    op_page2 <= p2;
    op_code <= op;
    op_post <= pb;
    mem_byte <= mb;
    eff_addr <= ea;
    next_page2 <= np;
    @(posedge core_clk);
    issue <= 1'b0;
    #1 n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("CHECK FAILED %0t timeout", $time);
      wrap_up;
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, issue, op_page2, next_page2} = '0;
    {reg_addr, op_code, op_post, mem_byte, reg_wdata, eff_addr} = '0;
    seed = 32'h695eecba;
    ops = '{8'h88, 8'h98, 8'hB8, 8'hA8, 8'hC8, 8'hD8, 8'hF8, 8'hE8};
    bad = '{8'hE0, 8'hE2, 8'hE3, 8'hE7, 8'hFB};
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h40, y);
    chk(y, 0, "unmapped read");
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      c = $random(seed);
      e = $random(seed);
      if (i % 5 == 0) e[7:0] = e[10] ? d[7:0] : d[15:8];
      wr(8'h00, d);
      wr(8'h02, {8'h00, c});
      run(1'b0, ops[e[10:8]], 8'h00, e[7:0], 16'h0000, 1'b0);
      r8 = (e[10] ? d[7:0] : d[15:8]) ^ e[7:0];
      chk(n, 0, "xor done");
      y = e[10] ? {d[15:8], r8} : {r8, d[7:0]};
      chk({acc_a, acc_b}, y, "xor");
      chk(condition_flag_register, {c[7:4], r8[7], r8 == 0, 1'b0, c[0]},
          "xor flags");
    end
    for (int i = 0; i < 30; i++) begin
      d = (i == 0) ? 16'h8000 : (i == 1) ? 16'hFFFF : $random(seed);
      y = (i == 0) ? 16'h8000 : (i == 1) ? 16'h0001 : $random(seed);
      c = $random(seed);
      wr(8'h00, d);
      wr(8'h01, y);
      wr(8'h02, {8'h00, c});
      run(1'b1, 8'h13, 8'h00, 8'h00, 16'h0000, c[1]);
      p = smul(d, y);
      chk(n, 2 + c[1], "mul done");
      chk({idx_y, acc_a, acc_b}, p, "mul");
      chk(condition_flag_register, {c[7:4], p[31], p == 0, c[1], p[15]},
          "mul flags");
    end
    for (int i = 0; i < 256; i++) mxi_tbl_mem_inst.mem[i] = $random(seed);
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      y = $random(seed);
      e = $random(seed);
      c = $random(seed);
      if (c[7:5] == 3'b111) c[2:0] = {2'b10, c[0]};
      if (i < 2) d[7:0] = i ? 8'hFF : 8'h00;
      wr(8'h00, d);
      wr(8'h02, {8'h00, y[7:0]});
      run(1'b1, 8'h3F, c, 8'h00, e, 1'b0);
      r = interp(mxi_tbl_mem_inst.mem[e[8:1]],
                 mxi_tbl_mem_inst.mem[e[8:1] + 8'h01], d[7:0]);
      chk(n, 8, "tbl done");
      chk({acc_a, acc_b}, r[15:0], "tbl");
      chk(condition_flag_register, {y[7:4], r[15], r[15:0] == 0, y[1],
          r[16]}, "tbl flags");
    end
    foreach (bad[i]) begin
      run(1'b1, 8'h3F, bad[i], 8'h00, 16'h0000, 1'b0);
      chk(n, 20, "bad postbyte");
    end
    rd(8'h03, y);
    chk(y[1], 1, "sticky refusal");
    wr(8'h03, 16'h0002);
    rd(8'h03, y);
    chk(y, 0, "sticky clear");
    wr(8'h01, 16'hA5C3);
    rd(8'h01, y);
    chk(y, 16'hA5C3, "y readback");
    run(1'b0, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
    chk(n, 20, "unknown opcode");
    wrap_up;
  end
endmodule
